/* File: vm_regs_pkg.sv */
package vm_regs_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [11:0] TYPE_OFFSET = 12'h004;
  localparam logic [11:0] STATE_OFFSET = 12'h008;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Type word fields and codes
  localparam int PRI_MSB = 31;
  localparam int PRI_LSB = 29;
  localparam int PRE_MSB = 28;
  localparam int PRE_LSB = 26;
  localparam int LIST_MSB = 5;
  localparam int LIST_LSB = 0;
  localparam logic [2:0] PRI_CODE = 3'h4;
  localparam logic [2:0] PRE_CODE = 3'h4;
  localparam logic [5:0] LIST_CODE = 6'h03;

  // State word field positions
  localparam int PMASK_MSB = 31;
  localparam int PMASK_LSB = 27;
  localparam int BP_MSB = 23;
  localparam int BP_LSB = 21;
  localparam int ABP_MSB = 20;
  localparam int ABP_LSB = 18;
  localparam int EOIMODE_BIT = 9;
  localparam int CBPR_BIT = 4;
  localparam int FIQ_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int G1EN_BIT = 1;
  localparam int G0EN_BIT = 0;
  localparam logic [31:0] STATE_RW_MASK = 32'hF8FC_021F;

  // Reset values and binary point limits
  localparam logic [2:0] BP_MIN = 3'h2;
  localparam logic [2:0] BP_SAT = 3'h7;
  localparam logic [4:0] PMASK_RESET = 5'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;

  // Live virtual interface state
  typedef struct packed {
    logic [4:0] priority_mask;
    logic [2:0] binary_point;
    logic [2:0] group1_point;
    logic split_completion;
    logic common_point;
    logic fast_irq;
    logic ack_control;
    logic group1_enable;
    logic group0_enable;
  } vm_state_type;

  // Binary point plus one, saturated
  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == BP_SAT) ? BP_SAT : v + 3'h1;
  endfunction : sat_inc

  // Raise a value to a floor
  function automatic logic [2:0] clamp_up(input logic [2:0] v, input logic [2:0] floor_v);
    clamp_up = (v < floor_v) ? floor_v : v;
  endfunction : clamp_up

  localparam logic [2:0] BP_RESET = BP_MIN;
  localparam logic [2:0] ABP_RESET = sat_inc(BP_MIN);

  // Pack the live state into the register image
  function automatic logic [31:0] pack_state(input vm_state_type s);
    logic [31:0] w;
    w = READ_ZERO;
    w[PMASK_MSB:PMASK_LSB] = s.priority_mask;
    w[BP_MSB:BP_LSB] = s.binary_point;
    w[ABP_MSB:ABP_LSB] = s.group1_point;
    w[EOIMODE_BIT] = s.split_completion;
    w[CBPR_BIT] = s.common_point;
    w[FIQ_BIT] = s.fast_irq;
    w[ACK_BIT] = s.ack_control;
    w[G1EN_BIT] = s.group1_enable;
    w[G0EN_BIT] = s.group0_enable;
    pack_state = w;
  endfunction : pack_state

endpackage : vm_regs_pkg

/* File: vm_state_if.sv */
// Carrier between the bus front end and the state store
interface vm_state_if;
  // Hypervisor full-word write, already lane-merged and masked
  logic hyp_we;
  logic [31:0] hyp_wdata;
  // Updates from the virtual interface's own registers
  logic vif_pmask_we;
  logic [4:0] vif_pmask;
  logic vif_bp_we;
  logic [2:0] vif_bp;
  logic vif_abp_we;
  logic [2:0] vif_abp;
  logic vif_ctl_we;
  logic [5:0] vif_ctl;
  // Current live state
  vm_regs_pkg::vm_state_type state;

  modport ctrl (
    output hyp_we, hyp_wdata, vif_pmask_we, vif_pmask, vif_bp_we, vif_bp,
    output vif_abp_we, vif_abp, vif_ctl_we, vif_ctl,
    input state
  );
  modport store (
    input hyp_we, hyp_wdata, vif_pmask_we, vif_pmask, vif_bp_we, vif_bp,
    input vif_abp_we, vif_abp, vif_ctl_we, vif_ctl,
    output state
  );
endinterface : vm_state_if

/* File: vm_type_word.sv */
// Constant implementation type word
module vm_type_word (
  // Assembled word
  output logic [31:0] type_word
);

  // Fixed fields, reserved bits zero; nothing can write this
  always_comb begin
    type_word = vm_regs_pkg::READ_ZERO;
    type_word[vm_regs_pkg::PRI_MSB:vm_regs_pkg::PRI_LSB] = vm_regs_pkg::PRI_CODE;
    type_word[vm_regs_pkg::PRE_MSB:vm_regs_pkg::PRE_LSB] = vm_regs_pkg::PRE_CODE;
    type_word[vm_regs_pkg::LIST_MSB:vm_regs_pkg::LIST_LSB] = vm_regs_pkg::LIST_CODE;
  end

endmodule : vm_type_word

/* File: vm_state_store.sv */
// Live virtual interface state, shared by hypervisor and virtual interface
module vm_state_store (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Update and readback carrier
  vm_state_if.store sif
);

  // Floor for the group 1 point follows the smallest binary point
  localparam logic [2:0] ABP_FLOOR = vm_regs_pkg::ABP_RESET;

  // Priority mask; the hypervisor restore wins over a same-cycle guest write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.state.priority_mask <= vm_regs_pkg::PMASK_RESET;
    end else if (sif.hyp_we) begin
      sif.state.priority_mask <= sif.hyp_wdata[vm_regs_pkg::PMASK_MSB:vm_regs_pkg::PMASK_LSB];
    end else if (sif.vif_pmask_we) begin
      sif.state.priority_mask <= sif.vif_pmask;
    end
  end

  // Binary point, never below the supported minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.state.binary_point <= vm_regs_pkg::BP_RESET;
    end else if (sif.hyp_we) begin
      sif.state.binary_point <= vm_regs_pkg::clamp_up(
        sif.hyp_wdata[vm_regs_pkg::BP_MSB:vm_regs_pkg::BP_LSB], vm_regs_pkg::BP_MIN);
    end else if (sif.vif_bp_we) begin
      sif.state.binary_point <= vm_regs_pkg::clamp_up(sif.vif_bp, vm_regs_pkg::BP_MIN);
    end
  end

  // Group 1 binary point, floor is minimum plus one saturated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.state.group1_point <= vm_regs_pkg::ABP_RESET;
    end else if (sif.hyp_we) begin
      sif.state.group1_point <= vm_regs_pkg::clamp_up(
        sif.hyp_wdata[vm_regs_pkg::ABP_MSB:vm_regs_pkg::ABP_LSB], ABP_FLOOR);
    end else if (sif.vif_abp_we) begin
      sif.state.group1_point <= vm_regs_pkg::clamp_up(sif.vif_abp, ABP_FLOOR);
    end
  end

  // Control bits, all taken together in one access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sif.state.split_completion, sif.state.common_point, sif.state.fast_irq,
       sif.state.ack_control, sif.state.group1_enable, sif.state.group0_enable}
        <= vm_regs_pkg::CTL_RESET;
    end else if (sif.hyp_we) begin
      {sif.state.split_completion, sif.state.common_point, sif.state.fast_irq,
       sif.state.ack_control, sif.state.group1_enable, sif.state.group0_enable}
        <= {sif.hyp_wdata[vm_regs_pkg::EOIMODE_BIT], sif.hyp_wdata[vm_regs_pkg::CBPR_BIT],
            sif.hyp_wdata[vm_regs_pkg::FIQ_BIT], sif.hyp_wdata[vm_regs_pkg::ACK_BIT],
            sif.hyp_wdata[vm_regs_pkg::G1EN_BIT], sif.hyp_wdata[vm_regs_pkg::G0EN_BIT]};
    end else if (sif.vif_ctl_we) begin
      {sif.state.split_completion, sif.state.common_point, sif.state.fast_irq,
       sif.state.ack_control, sif.state.group1_enable, sif.state.group0_enable}
        <= sif.vif_ctl;
    end
  end

endmodule : vm_state_store

/* File: vm_interface_state_regs.sv */
// Function
// - Read-only type word, writes ignored
// - Bits 31:29 give priority bits minus one
// - Bits 28:26 give preemption bits minus one
// - Bits 5:0 give list entries minus one
// - State word aliases live state, mask 31:27
// - One access saves or restores all state
// - Bits 23:21 alias binary point
// - Binary point resets to supported minimum
// - Bits 20:18 alias group 1 point
// - Group 1 point resets to minimum+1, max 7
module vm_interface_state_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Virtual interface register updates
  input wire logic virt_priority_mask_reg_we,
  input wire logic [4:0] virt_priority_mask_reg_wdata,
  input wire logic virt_binary_point_reg_we,
  input wire logic [2:0] virt_binary_point_reg_wdata,
  input wire logic virt_group1_point_reg_we,
  input wire logic [2:0] virt_group1_point_reg_wdata,
  input wire logic virt_cpu_control_reg_we,
  input wire logic [5:0] virt_cpu_control_reg_wdata,
  // Live state presented to the virtual interface
  output logic [4:0] vm_priority_mask,
  output logic [2:0] vm_binary_point,
  output logic [2:0] vm_group1_binary_point,
  output logic vm_split_completion_mode,
  output logic vm_common_point_select,
  output logic vm_fast_irq_enable,
  output logic vm_ack_control,
  output logic vm_group1_enable,
  output logic vm_group0_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Registered bus answer
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Decode of the current request
  logic setup_phase; // First cycle of a transfer
  logic access_done; // Completion edge of a transfer
  logic hit_type; // Type word addressed
  logic hit_state; // State word addressed
  logic hit_any; // Any mapped word addressed

  // Views of the two words
  logic [31:0] type_word; // Constant type image
  logic [31:0] state_word; // Packed live state
  logic [31:0] merged_wdata; // Lane-merged write image

  // Carrier to the state store
  vm_state_if sif ();

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Merge write data into an old word under byte strobes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction : lane_merge

  // Word-aligned match of an address against an offset
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] offs);
    addr_hit = (a[11:2] == offs[11:2]);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  // Constant type word
  vm_type_word u_type (
    .type_word(type_word)
  );

  // Live state storage
  vm_state_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Phases and hits; low address bits are ignored, every word is aligned
  always_comb begin
    setup_phase = psel && !penable;
    access_done = psel && penable && pready_q;
    hit_type = addr_hit(paddr, vm_regs_pkg::TYPE_OFFSET);
    hit_state = addr_hit(paddr, vm_regs_pkg::STATE_OFFSET);
    hit_any = hit_type || hit_state;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State word image

  // Reserved positions are zero in the packed image
  always_comb begin
    state_word = vm_regs_pkg::pack_state(sif.state) & vm_regs_pkg::STATE_RW_MASK;
  end

  // Partial writes keep untouched lanes; reserved bits are dropped
  always_comb begin
    merged_wdata = lane_merge(state_word, pwdata, pstrb) & vm_regs_pkg::STATE_RW_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hypervisor write path

  // A state write lands only at the completion edge; type writes go nowhere
  always_comb begin
    sif.hyp_we = access_done && pwrite && hit_state;
    sif.hyp_wdata = merged_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Virtual interface update path

  // Guest-side register writes keep the aliases live
  always_comb begin
    sif.vif_pmask_we = virt_priority_mask_reg_we;
    sif.vif_pmask = virt_priority_mask_reg_wdata;
    sif.vif_bp_we = virt_binary_point_reg_we;
    sif.vif_bp = virt_binary_point_reg_wdata;
    sif.vif_abp_we = virt_group1_point_reg_we;
    sif.vif_abp = virt_group1_point_reg_wdata;
    sif.vif_ctl_we = virt_cpu_control_reg_we;
    sif.vif_ctl = virt_cpu_control_reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer, next values

  // No wait state: ready rises in the first access cycle
  always_comb begin
    pready_d = setup_phase;
  end

  // Unmapped words answer with an error; mapped ones never do
  always_comb begin
    pslverr_d = setup_phase && !hit_any;
  end

  // Read data sampled in setup; writes and misses read as zero
  always_comb begin
    prdata_d = vm_regs_pkg::READ_ZERO;
    if (setup_phase && !pwrite) begin
      if (hit_type) begin
        prdata_d = type_word;
      end else if (hit_state) begin
        prdata_d = state_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer, registers

  // Ready pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  // Error flag, valid alongside ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  // Read data; a guest write in the access cycle is not reflected,
  // trading one cycle of staleness for a registered output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= vm_regs_pkg::READ_ZERO;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus outputs straight from their flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Live state straight from the store flops
  assign vm_priority_mask = sif.state.priority_mask;
  assign vm_binary_point = sif.state.binary_point;
  assign vm_group1_binary_point = sif.state.group1_point;
  assign vm_split_completion_mode = sif.state.split_completion;
  assign vm_common_point_select = sif.state.common_point;
  assign vm_fast_irq_enable = sif.state.fast_irq;
  assign vm_ack_control = sif.state.ack_control;
  assign vm_group1_enable = sif.state.group1_enable;
  assign vm_group0_enable = sif.state.group0_enable;

endmodule : vm_interface_state_regs

/* File: vm_state_checker.sv */
// Watches the top-level ports of the state register block
module vm_state_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Guest update
  input wire logic virt_priority_mask_reg_we,
  input wire logic [4:0] virt_priority_mask_reg_wdata,
  // Live state
  input wire logic [4:0] vm_priority_mask,
  input wire logic [2:0] vm_binary_point,
  input wire logic [2:0] vm_group1_binary_point,
  input wire logic vm_split_completion_mode,
  input wire logic vm_common_point_select,
  input wire logic vm_fast_irq_enable,
  input wire logic vm_ack_control,
  input wire logic vm_group1_enable,
  input wire logic vm_group0_enable
);
  ////////////////////////////////////////////////////////////////////////////////
  // Decode, kept independent of the design's own constants
  logic is_type;
  logic is_state;
  logic [31:0] live;
  assign is_type = (paddr[11:2] == 10'h001);
  assign is_state = (paddr[11:2] == 10'h002);
  // Reserved positions forced to zero in the expected image
  assign live = {vm_priority_mask, 3'h0, vm_binary_point, vm_group1_binary_point, 8'h00,
    vm_split_completion_mode, 4'h0, vm_common_point_select, vm_fast_irq_enable,
    vm_ack_control, vm_group1_enable, vm_group0_enable};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_error_a: assert property (pready |-> (pslverr == !(is_type || is_state)))
    else $error("error response wrong for address");
  type_word_a: assert property (pready && !pwrite && is_type |-> prdata == 32'h9000_0003)
    else $error("type word wrong");
  read_idle_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  state_read_a: assert property (pready && !pwrite && is_state |-> prdata == $past(live))
    else $error("state read differs from live state");
  state_write_a: assert property (pready && pwrite && is_state && pstrb == 4'hF |=>
    {vm_priority_mask, vm_split_completion_mode, vm_group0_enable} ==
    {$past(pwdata[31:27]), $past(pwdata[9]), $past(pwdata[0])})
    else $error("state write not applied");
  guest_mask_a: assert property (virt_priority_mask_reg_we && !(pready && pwrite && is_state)
    |=> vm_priority_mask == $past(virt_priority_mask_reg_wdata))
    else $error("guest mask update lost");
  point_floor_a: assert property (vm_binary_point >= 3'h2 && vm_group1_binary_point >= 3'h3)
    else $error("binary point below floor");

  // Main scenarios reached
  cover property (pready && !pwrite && is_type);
  cover property (pready && pslverr);
  cover property (virt_priority_mask_reg_we);
  cover property (pready && pwrite && is_state && virt_priority_mask_reg_we);
  cover property (pready ##1 (psel && !penable));
endmodule : vm_state_checker

bind vm_interface_state_regs vm_state_checker u_vm_state_checker (.*);

/* File: vm_interface_state_regs_tb_top.sv */
module vm_interface_state_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, live;
  logic [3:0] pstrb, gwe;
  logic [5:0] gv;
  logic [4:0] pm;
  logic [2:0] bp, abp;
  logic sc, cp, fq, ak, g1, g0;
  int error_cnt = 0;
  int comparisons = 0;
  assign live = {pm, 3'h0, bp, abp, 8'h00, sc, 4'h0, cp, fq, ak, g1, g0};

  vm_interface_state_regs u_vm_interface_state_regs (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr),
    .virt_priority_mask_reg_we(gwe[0]), .virt_priority_mask_reg_wdata(gv[4:0]),
    .virt_binary_point_reg_we(gwe[1]), .virt_binary_point_reg_wdata(gv[2:0]),
    .virt_group1_point_reg_we(gwe[2]), .virt_group1_point_reg_wdata(gv[2:0]),
    .virt_cpu_control_reg_we(gwe[3]), .virt_cpu_control_reg_wdata(gv),
    .vm_priority_mask(pm), .vm_binary_point(bp), .vm_group1_binary_point(abp),
    .vm_split_completion_mode(sc), .vm_common_point_select(cp), .vm_fast_irq_enable(fq),
    .vm_ack_control(ak), .vm_group1_enable(g1), .vm_group0_enable(g0));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer begun just after an edge; last releases the bus,
  // otherwise the next setup follows at once with psel held high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, input logic [31:0] er, input logic ee, input logic last);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers is a mismatch, not a silent pass
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: no ready from slave", $time);
    end
    // Data and response are taken at the completing edge only
    chk(prdata, er);
    chk({31'h0, pslverr}, {31'h0, ee});
    if (last) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer

  // One APB transfer after an idle cycle
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, input logic [31:0] er, input logic ee);
    @(posedge pclk);
    xfer(a, w, d, s, er, ee, 1'b1);
  endtask : acc

  // Read the state word and compare the live outputs too
  task automatic st(input logic [31:0] e);
    acc(12'h008, 1'b0, 32'h0, 4'hF, e, 1'b0);
    chk(live, e);
  endtask : st

  // Guest-side update pulse, one enable per source
  task automatic guest(input logic [3:0] w, input logic [5:0] v);
    @(posedge pclk);
    gwe <= w;
    gv <= v;
    @(posedge pclk);
    gwe <= 4'h0;
  endtask : guest

  task automatic tally_and_finish;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, gwe, gv} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    acc(12'h004, 1'b0, 32'h0, 4'hF, 32'h9000_0003, 1'b0);
    st(32'h004C_0000);
    acc(12'h004, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    acc(12'h004, 1'b0, 32'h0, 4'hF, 32'h9000_0003, 1'b0);
    acc(12'h008, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    st(32'hF8FC_021F);
    acc(12'h008, 1'b1, 32'h0, 4'hF, 32'h0, 1'b0);
    st(32'h004C_0000);
    acc(12'h008, 1'b1, 32'hA8B8_0215, 4'hF, 32'h0, 1'b0);
    st(32'hA8B8_0215);
    // Only the low lane is written
    acc(12'h008, 1'b1, 32'h0, 4'h1, 32'h0, 1'b0);
    st(32'hA8B8_0200);
    // Unmapped accesses answer with an error and change nothing
    acc(12'h00C, 1'b0, 32'h0, 4'hF, 32'h0, 1'b1);
    acc(12'h000, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
    st(32'hA8B8_0200);
    // Guest updates seen through the alias word
    guest(4'hF, 6'h21);
    st(32'h084C_0201);
    guest(4'hF, 6'h1E);
    st(32'hF0D8_001E);
    guest(4'h2, 6'h05);
    st(32'hF0B8_001E);
    // Second reset in mid-run restores the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h004C_0000);
    // Back-to-back transfers with no idle cycle between them
    @(posedge pclk);
    xfer(12'h008, 1'b1, 32'h5070_020A, 4'hF, 32'h0, 1'b0, 1'b0);
    xfer(12'h008, 1'b0, 32'h0, 4'hF, 32'h5070_020A, 1'b0, 1'b0);
    xfer(12'h004, 1'b0, 32'h0, 4'hF, 32'h9000_0003, 1'b0, 1'b1);
    // Each guest source alone; values below the floor are raised
    guest(4'h1, 6'h1F);
    st(32'hF870_020A);
    guest(4'h4, 6'h01);
    st(32'hF86C_020A);
    guest(4'h8, 6'h35);
    st(32'hF86C_0215);
    guest(4'h2, 6'h00);
    st(32'hF84C_0215);
    // A restore on the same edge as guest updates wins
    fork
      acc(12'h008, 1'b1, 32'h0, 4'hF, 32'h0, 1'b0);
      begin
        repeat (2) @(posedge pclk);
        gwe <= 4'hF;
        gv <= 6'h3F;
        @(posedge pclk);
        gwe <= 4'h0;
      end
    join
    st(32'h004C_0000);
    tally_and_finish();
  end
endmodule : vm_interface_state_regs_tb_top
